// ### design/l2pcf_pkg.sv
// Purpose: Shared constants and types of the layer-2 priority and forwarding path
// Assumes: Eight ports, the top two of them gigabit
// Notes: Queue codes are common to both port types
package l2pcf_pkg;
  localparam int NPORT = 8;
  localparam int PORT_W = 3;
  localparam logic [PORT_W-1:0] GIG_FIRST = 3'h6;
  localparam int MAC_W = 48;
  localparam int VID_W = 12;
  localparam int PRIO_W = 3;
  localparam int CAM_DEPTH = 8192;
  localparam int CAM_AW = 13;
  localparam int CNT_W = 16;
  localparam logic [VID_W-1:0] VID_NONE = 12'h000;
  localparam logic [PRIO_W-1:0] GIG_HIGH_MIN = 3'h4;
  localparam logic [PRIO_W-1:0] FE_NORMAL_MIN = 3'h2;
  localparam logic [PRIO_W-1:0] FE_HIGH_MIN = 3'h4;
  localparam logic [PRIO_W-1:0] FE_HIGHEST_MIN = 3'h6;
  localparam logic [PRIO_W-1:0] GIG_TAG_HIGH = 3'h4;
  localparam logic [PRIO_W-1:0] GIG_TAG_NORMAL = 3'h0;
  localparam logic [PRIO_W-1:0] RST_PORT_PRIO = 3'h0;
  localparam logic [VID_W-1:0] RST_PORT_VID = 12'h001;
  localparam logic RST_TAG_MODE = 1'b0;
  localparam logic [CNT_W-1:0] RST_CNT = 16'h0000;

  typedef enum logic [1:0] {
    L2PCF_Q_LOW = 2'b00,
    L2PCF_Q_NORMAL = 2'b01,
    L2PCF_Q_HIGH = 2'b10,
    L2PCF_Q_HIGHEST = 2'b11
  } l2pcf_queue_t;
endpackage

// ### design/l2pcf_classify.sv
// Purpose: Priority classification of one frame
// Assumes: Priority already chosen between tag and port setting
// Notes: Purely combinational
`timescale 1ns/1ps
module l2pcf_classify (
  input wire logic [l2pcf_pkg::PRIO_W-1:0] i_prio,
  input wire logic i_from_tag,
  input wire logic i_ingress_gig,
  output l2pcf_pkg::l2pcf_queue_t o_gig_queue,
  output l2pcf_pkg::l2pcf_queue_t o_fe_queue,
  output logic [l2pcf_pkg::PRIO_W-1:0] o_egress_prio
);
  import l2pcf_pkg::*;

  always_comb begin
    if (i_prio >= GIG_HIGH_MIN) begin
      o_gig_queue = L2PCF_Q_HIGH; // R02
    end else begin
      o_gig_queue = L2PCF_Q_NORMAL; // R03
    end
  end

  always_comb begin
    if (i_prio >= FE_HIGHEST_MIN) begin
      o_fe_queue = L2PCF_Q_HIGHEST; // R05
    end else if (i_prio >= FE_HIGH_MIN) begin
      o_fe_queue = L2PCF_Q_HIGH; // R05
    end else if (i_prio >= FE_NORMAL_MIN) begin
      o_fe_queue = L2PCF_Q_NORMAL; // R04
    end else begin
      o_fe_queue = L2PCF_Q_LOW; // R04
    end
  end

  always_comb begin
    if (i_from_tag) begin
      o_egress_prio = i_prio; // R07
    end else if (i_ingress_gig) begin
      o_egress_prio = (o_gig_queue == L2PCF_Q_HIGH) ? GIG_TAG_HIGH : GIG_TAG_NORMAL; // R08
    end else begin
      o_egress_prio = i_prio; // R09
    end
  end
endmodule // l2pcf_classify

// ### design/l2pcf_cam.sv
// Purpose: Learned address table, direct mapped by a hash
// Assumes: One lookup and one learn per cycle
// Notes: A colliding address overwrites the older entry
`timescale 1ns/1ps
module l2pcf_cam (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic [l2pcf_pkg::MAC_W-1:0] i_dst_mac,
  input wire logic [l2pcf_pkg::VID_W-1:0] i_dst_vid,
  output logic o_dst_hit,
  output logic [l2pcf_pkg::PORT_W-1:0] o_dst_port,
  input wire logic i_learn_en,
  input wire logic [l2pcf_pkg::MAC_W-1:0] i_src_mac,
  input wire logic [l2pcf_pkg::VID_W-1:0] i_src_vid,
  input wire logic [l2pcf_pkg::PORT_W-1:0] i_src_port,
  output logic o_learn
);
  import l2pcf_pkg::*;

  logic valid_q [CAM_DEPTH];
  logic [MAC_W-1:0] mac_q [CAM_DEPTH];
  logic [VID_W-1:0] vid_q [CAM_DEPTH];
  logic [PORT_W-1:0] port_q [CAM_DEPTH];
  logic [CAM_AW-1:0] dst_idx;
  logic [CAM_AW-1:0] src_idx;
  logic src_known;

  // Folds address and VLAN into a table index
  function automatic logic [CAM_AW-1:0] hash_idx(input logic [MAC_W-1:0] mac,
                                                 input logic [VID_W-1:0] vid);
    logic [CAM_AW-1:0] h;
    h = mac[12:0] ^ mac[25:13] ^ mac[38:26];
    h = h ^ {4'h0, mac[47:39]} ^ {1'b0, vid};
    return h;
  endfunction

  assign dst_idx = hash_idx(i_dst_mac, i_dst_vid);
  assign src_idx = hash_idx(i_src_mac, i_src_vid);

  // Entry matches on both address and VLAN
  assign o_dst_hit = valid_q[dst_idx] && (mac_q[dst_idx] == i_dst_mac)
                     && (vid_q[dst_idx] == i_dst_vid); // R10
  assign o_dst_port = port_q[dst_idx];

  assign src_known = valid_q[src_idx] && (mac_q[src_idx] == i_src_mac)
                     && (vid_q[src_idx] == i_src_vid)
                     && (port_q[src_idx] == i_src_port);

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      for (int i = 0; i < CAM_DEPTH; i++) begin
        valid_q[i] <= 1'b0;
      end
    end else if (i_learn_en && !src_known) begin
      valid_q[src_idx] <= 1'b1; // R13
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_learn_en && !src_known) begin
      mac_q[src_idx] <= i_src_mac; // R13
      vid_q[src_idx] <= i_src_vid; // R10
      port_q[src_idx] <= i_src_port; // R10
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_learn <= 1'b0;
    end else begin
      o_learn <= i_learn_en && !src_known;
    end
  end
endmodule // l2pcf_cam

// ### design/l2pcf_top.sv
// Purpose: Ingress classification, tag priority and forwarding of frame headers
// Assumes: Header descriptors and settings come from logic on i_sys_clk
// Notes: One header per cycle; result held until taken
// Function
// R01: Gigabit ports have two queues, 10/100 ports have four.
// R02: Gigabit ports queue priorities 4 to 7 as high.
// R03: Gigabit ports queue priorities 0 to 3 as normal.
// R04: 10/100 ports queue 0-1 as low, 2-3 as normal.
// R05: 10/100 ports queue 4-5 as high, 6-7 as highest.
// R06: Tagged frames classify by tag, untagged by ingress port priority.
// R07: Tagged frames keep their original priority on tagging egress.
// R08: Untagged gigabit ingress frames tag 4 if high, 0 if normal.
// R09: Untagged 10/100 ingress frames tag with the port's set priority.
// R10: Table links learned 48-bit addresses to a port and VLAN.
// R11: Known destination goes only to its recorded port.
// R12: Unknown destination or changed mapping floods to all ports.
// R13: Source of an unknown station is learned into the table.
// R14: Table holds up to 8K entries.
// R15: Untagged or VLAN-zero frames take the port's default VLAN.
// R16: Each port's priority is a three-bit software-written setting.
`timescale 1ns/1ps
module l2pcf_top (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_cfg_we,
  input wire logic [l2pcf_pkg::PORT_W-1:0] i_cfg_port,
  input wire logic [l2pcf_pkg::PRIO_W-1:0] i_cfg_prio,
  input wire logic [l2pcf_pkg::VID_W-1:0] i_cfg_vid,
  input wire logic i_cfg_tag_mode,
  output logic [l2pcf_pkg::PRIO_W-1:0] o_cfg_prio_rd,
  output logic [l2pcf_pkg::VID_W-1:0] o_cfg_vid_rd,
  input wire logic i_hdr_valid,
  output logic o_hdr_ready,
  input wire logic [l2pcf_pkg::PORT_W-1:0] i_hdr_port,
  input wire logic i_hdr_tagged,
  input wire logic [l2pcf_pkg::PRIO_W-1:0] i_hdr_prio,
  input wire logic [l2pcf_pkg::VID_W-1:0] i_hdr_vid,
  input wire logic [l2pcf_pkg::MAC_W-1:0] i_hdr_dst,
  input wire logic [l2pcf_pkg::MAC_W-1:0] i_hdr_src,
  input wire logic i_fwd_ready,
  output logic o_fwd_valid,
  output logic [l2pcf_pkg::NPORT-1:0] o_fwd_mask,
  output logic [l2pcf_pkg::NPORT-1:0] o_fwd_tag_mask,
  output logic [2*l2pcf_pkg::NPORT-1:0] o_fwd_queue,
  output logic [l2pcf_pkg::PRIO_W-1:0] o_fwd_prio,
  output logic [l2pcf_pkg::VID_W-1:0] o_fwd_vid,
  output logic o_fwd_flood,
  output logic o_learn,
  output logic [l2pcf_pkg::CNT_W-1:0] o_hit_cnt,
  output logic [l2pcf_pkg::CNT_W-1:0] o_flood_cnt
);
  import l2pcf_pkg::*;

  logic [PRIO_W-1:0] port_prio_q [NPORT];
  logic [VID_W-1:0] port_vid_q [NPORT];
  logic [NPORT-1:0] tag_mode_q;
  logic take;
  logic ingress_gig;
  logic [PRIO_W-1:0] eff_prio;
  logic [VID_W-1:0] eff_vid;
  l2pcf_queue_t gig_queue;
  l2pcf_queue_t fe_queue;
  logic [PRIO_W-1:0] egress_prio;
  logic dst_hit;
  logic [PORT_W-1:0] dst_port;
  logic known;
  logic [NPORT-1:0] mask_d;
  logic [2*NPORT-1:0] queue_d;
  logic fwd_valid_q;
  logic [NPORT-1:0] fwd_mask_q;
  logic [NPORT-1:0] fwd_tag_mask_q;
  logic [2*NPORT-1:0] fwd_queue_q;
  logic [PRIO_W-1:0] fwd_prio_q;
  logic [VID_W-1:0] fwd_vid_q;
  logic fwd_flood_q;
  logic [CNT_W-1:0] hit_cnt_q;
  logic [CNT_W-1:0] flood_cnt_q;

  // Tells whether a port is one of the gigabit ports
  function automatic logic is_gig(input logic [PORT_W-1:0] port);
    logic gig;
    gig = 1'b0;
    if (port >= GIG_FIRST) begin
      gig = 1'b1;
    end
    return gig;
  endfunction

  // Per-port settings written by management
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      for (int i = 0; i < NPORT; i++) begin
        port_prio_q[i] <= RST_PORT_PRIO;
      end
    end else if (i_cfg_we) begin
      port_prio_q[i_cfg_port] <= i_cfg_prio; // R16
    end
  end

  // Default VLAN of each ingress port
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      for (int i = 0; i < NPORT; i++) begin
        port_vid_q[i] <= RST_PORT_VID;
      end
    end else if (i_cfg_we) begin
      port_vid_q[i_cfg_port] <= i_cfg_vid;
    end
  end

  // Tagging mode of each egress port
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      for (int i = 0; i < NPORT; i++) begin
        tag_mode_q[i] <= RST_TAG_MODE;
      end
    end else if (i_cfg_we) begin
      tag_mode_q[i_cfg_port] <= i_cfg_tag_mode;
    end
  end

  // Readback of the priority and VLAN settings of the addressed port
  always_comb begin
    o_cfg_prio_rd = port_prio_q[i_cfg_port]; // R16
    o_cfg_vid_rd = port_vid_q[i_cfg_port];
  end

  // Header is taken when the result slot is free or draining
  assign o_hdr_ready = !fwd_valid_q || i_fwd_ready;

  // Accepted header this cycle
  assign take = i_hdr_valid && o_hdr_ready;

  // Port type of the ingress port
  assign ingress_gig = is_gig(i_hdr_port);

  // Priority source: tag if present, else port setting
  always_comb begin
    if (i_hdr_tagged) begin
      eff_prio = i_hdr_prio; // R06
    end else begin
      eff_prio = port_prio_q[i_hdr_port]; // R06
    end
  end

  // Default VLAN for untagged and VLAN-zero frames
  always_comb begin
    if (!i_hdr_tagged || i_hdr_vid == VID_NONE) begin
      eff_vid = port_vid_q[i_hdr_port]; // R15
    end else begin
      eff_vid = i_hdr_vid; // R15
    end
  end

  // Queue choice and egress tag priority
  l2pcf_classify u_classify (
    .i_prio(eff_prio),
    .i_from_tag(i_hdr_tagged),
    .i_ingress_gig(ingress_gig),
    .o_gig_queue(gig_queue),
    .o_fe_queue(fe_queue),
    .o_egress_prio(egress_prio)
  );

  // Learned address table
  l2pcf_cam u_cam (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_dst_mac(i_hdr_dst),
    .i_dst_vid(eff_vid),
    .o_dst_hit(dst_hit),
    .o_dst_port(dst_port),
    .i_learn_en(take),
    .i_src_mac(i_hdr_src),
    .i_src_vid(eff_vid),
    .i_src_port(i_hdr_port),
    .o_learn(o_learn)
  ); // R14

  // A recorded port equal to the ingress port means the station moved
  always_comb begin
    known = 1'b0;
    if (dst_hit && (dst_port != i_hdr_port)) begin
      known = 1'b1; // R11
    end
  end

  // One port if known, else all ports
  always_comb begin
    mask_d = '0;
    if (known) begin
      mask_d[dst_port] = 1'b1; // R11
    end else begin
      mask_d = {NPORT{1'b1}}; // R12
    end
  end

  // Queue choice depends on the egress port type
  always_comb begin
    queue_d = '0;
    for (int p = 0; p < NPORT; p++) begin
      if (is_gig(PORT_W'(p))) begin
        queue_d[2*p +: 2] = gig_queue; // R01
      end else begin
        queue_d[2*p +: 2] = fe_queue; // R01
      end
    end
  end

  // Result slot, held until taken
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      fwd_valid_q <= 1'b0;
    end else if (take) begin
      fwd_valid_q <= 1'b1;
    end else if (i_fwd_ready) begin
      fwd_valid_q <= 1'b0;
    end
  end

  // Egress ports of the result
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      fwd_mask_q <= '0;
    end else if (take) begin
      fwd_mask_q <= mask_d; // R11
    end
  end

  // Tagging ports among the egress ports
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      fwd_tag_mask_q <= '0;
    end else if (take) begin
      fwd_tag_mask_q <= mask_d & tag_mode_q; // R07
    end
  end

  // Flood marker of the result
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      fwd_flood_q <= 1'b0;
    end else if (take) begin
      fwd_flood_q <= !known; // R12
    end
  end

  // Queue code of every egress port
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      fwd_queue_q <= '0;
    end else if (take) begin
      fwd_queue_q <= queue_d; // R01
    end
  end

  // Priority for the egress tag
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      fwd_prio_q <= '0;
    end else if (take) begin
      fwd_prio_q <= egress_prio; // R07
    end
  end

  // Effective VLAN of the result
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      fwd_vid_q <= '0;
    end else if (take) begin
      fwd_vid_q <= eff_vid; // R15
    end
  end

  // Count of headers sent to one known port
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      hit_cnt_q <= RST_CNT;
    end else if (take && known) begin
      hit_cnt_q <= hit_cnt_q + CNT_W'(1); // R11
    end
  end

  // Count of flooded headers
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      flood_cnt_q <= RST_CNT;
    end else if (take && !known) begin
      flood_cnt_q <= flood_cnt_q + CNT_W'(1); // R12
    end
  end

  // Registered results to the ports
  assign o_fwd_valid = fwd_valid_q;
  assign o_fwd_mask = fwd_mask_q;
  assign o_fwd_tag_mask = fwd_tag_mask_q;
  assign o_fwd_queue = fwd_queue_q;
  assign o_fwd_prio = fwd_prio_q;
  assign o_fwd_vid = fwd_vid_q;
  assign o_fwd_flood = fwd_flood_q;
  assign o_hit_cnt = hit_cnt_q;
  assign o_flood_cnt = flood_cnt_q;
endmodule // l2pcf_top

// ### dv/l2pcf_top_asserts.sv
// Purpose: Port checks of the priority and forwarding path
// Assumes: Bound to l2pcf_top, one clock domain
// Notes: Queue checks gated by the egress mask
`timescale 1ns/1ps
module l2pcf_top_asserts (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_hdr_valid,
  input wire logic o_hdr_ready,
  input wire logic i_hdr_tagged,
  input wire logic [2:0] i_hdr_prio,
  input wire logic [11:0] i_hdr_vid,
  input wire logic i_fwd_ready,
  input wire logic o_fwd_valid,
  input wire logic [7:0] o_fwd_mask,
  input wire logic [7:0] o_fwd_tag_mask,
  input wire logic [15:0] o_fwd_queue,
  input wire logic [2:0] o_fwd_prio,
  input wire logic [11:0] o_fwd_vid,
  input wire logic o_fwd_flood
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  sequence take_s; i_hdr_valid && o_hdr_ready; endsequence
  sequence tt_s; i_hdr_valid && o_hdr_ready && i_hdr_tagged; endsequence
  sequence stall_s; o_fwd_valid && !i_fwd_ready; endsequence
  result_next_a: assert property (take_s |=> o_fwd_valid)
    else $error("no result after take");
  result_hold_a: assert property (stall_s |=> o_fwd_valid && $stable(o_fwd_mask)
    && $stable(o_fwd_prio)) else $error("result changed in stall");
  flood_all_a: assert property (o_fwd_valid && o_fwd_flood |-> o_fwd_mask == 8'hFF)
    else $error("flood not to all");
  known_one_a: assert property (o_fwd_valid && !o_fwd_flood |-> $onehot(o_fwd_mask))
    else $error("known not one port");
  tag_sub_a: assert property (o_fwd_valid |-> (o_fwd_tag_mask & ~o_fwd_mask) == 8'h00)
    else $error("tag port outside mask");
  tag_prio_a: assert property (tt_s |=> o_fwd_prio == $past(i_hdr_prio))
    else $error("tag priority lost");
  tag_vid_a: assert property (tt_s ##0 i_hdr_vid != 12'h000 |=> o_fwd_vid == $past(i_hdr_vid))
    else $error("tag vlan lost");
  gig_queue_a: assert property (tt_s |=> !o_fwd_mask[7] ||
    o_fwd_queue[15:14] == ($past(i_hdr_prio) > 3 ? 2'h2 : 2'h1)) else $error("gig queue");
  fe_queue_a: assert property (tt_s |=> !o_fwd_mask[0] ||
    o_fwd_queue[1:0] == 2'($past(i_hdr_prio) >> 1)) else $error("fe queue");
endmodule // l2pcf_top_asserts
bind l2pcf_top l2pcf_top_asserts u_chk (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
  .i_hdr_valid(i_hdr_valid), .o_hdr_ready(o_hdr_ready), .i_hdr_tagged(i_hdr_tagged),
  .i_hdr_prio(i_hdr_prio), .i_hdr_vid(i_hdr_vid), .i_fwd_ready(i_fwd_ready),
  .o_fwd_valid(o_fwd_valid), .o_fwd_mask(o_fwd_mask), .o_fwd_tag_mask(o_fwd_tag_mask),
  .o_fwd_queue(o_fwd_queue), .o_fwd_prio(o_fwd_prio), .o_fwd_vid(o_fwd_vid),
  .o_fwd_flood(o_fwd_flood));

// ### dv/l2pcf_sink.sv
// Purpose: Result consumer on the egress side
// Assumes: Ready may drop in any cycle
// Notes: Stalls only while asked
`timescale 1ns/1ps
module l2pcf_sink (
  input wire logic i_sys_clk,
  input wire logic i_stall_en,
  output logic o_ready
);
  int sd = 32'hc99e1c79;
  initial o_ready = 1'b1;
  always @(posedge i_sys_clk) begin
    #1 o_ready = !i_stall_en || ($random(sd) % 3 != 0);
  end
endmodule // l2pcf_sink

// ### dv/l2_priority_cam_forwarding_tb.sv
// Purpose: Self-checking bench of the priority and forwarding path
// Assumes: Eight ports, results taken by the sink model
// Notes: Table model keyed by VLAN and address
`timescale 1ns/1ps
module l2_priority_cam_forwarding_tb;
  import l2pcf_pkg::*;
  typedef struct packed {
    logic [7:0] m, t; logic [15:0] q; logic [2:0] p; logic [11:0] v; logic f, l;
  } l2pcf_exp_t;
  logic clk = 0, rst = 1, we = 0, tm = 0, hv = 0, tg = 0, stall = 0, tk = 0;
  logic fr, hr, fv, fl, lrn;
  logic [2:0] cp = 0, cpr = 0, hp = 0, hpr = 0, prd, fp;
  logic [11:0] cv = 0, hvid = 0, vrd, fvid;
  logic [47:0] hd = 0, hs = 0;
  logic [7:0] msk, tmsk, tmode;
  logic [15:0] q, hc, fc;
  logic [2:0] pprio [8];
  logic [11:0] pvid [8];
  logic [2:0] tbl [logic [59:0]];
  logic [47:0] pool [6];
  logic [34:0] pool_hi;
  l2pcf_exp_t eq[$];
  int seed = 32'hc99e1c79, error_cnt = 0, checked = 0, nhit = 0, nfld = 0, cyc = 0;
  l2pcf_top u_dut (.i_sys_clk(clk), .i_rst(rst), .i_cfg_we(we), .i_cfg_port(cp),
    .i_cfg_prio(cpr), .i_cfg_vid(cv), .i_cfg_tag_mode(tm), .o_cfg_prio_rd(prd),
    .o_cfg_vid_rd(vrd), .i_hdr_valid(hv), .o_hdr_ready(hr), .i_hdr_port(hp),
    .i_hdr_tagged(tg), .i_hdr_prio(hpr), .i_hdr_vid(hvid), .i_hdr_dst(hd), .i_hdr_src(hs),
    .i_fwd_ready(fr), .o_fwd_valid(fv), .o_fwd_mask(msk), .o_fwd_tag_mask(tmsk),
    .o_fwd_queue(q), .o_fwd_prio(fp), .o_fwd_vid(fvid), .o_fwd_flood(fl), .o_learn(lrn),
    .o_hit_cnt(hc), .o_flood_cnt(fc));
  l2pcf_sink u_sink (.i_sys_clk(clk), .i_stall_en(stall), .o_ready(fr));
  task automatic chk(input logic [15:0] g, e);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic test_done;
    $display("checked=%0d errors=%0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic cfg(input int p);
    cp = 3'(p); cpr = 3'($random(seed)); cv = 12'({$random(seed)} % 9 + 1);
    tm = 1'($random(seed)); we = 1;
    pprio[p] = cpr; pvid[p] = cv; tmode[p] = tm;
    @(posedge clk) #1;
    chk(16'(prd), 16'(pprio[p]));
    chk(16'(vrd), 16'(pvid[p]));
  endtask
  task automatic send(input int p, input logic t, input logic [2:0] pr,
                      input logic [11:0] v, input logic [47:0] d, s);
    l2pcf_exp_t x;
    logic [2:0] ep;
    logic [11:0] ev;
    ep = t ? pr : pprio[p];
    ev = (t && v != 12'h000) ? v : pvid[p];
    x.f = !(tbl.exists({ev, d}) && tbl[{ev, d}] != 3'(p));
    x.m = x.f ? 8'hFF : 8'h01 << tbl[{ev, d}];
    x.t = x.m & tmode;
    for (int i = 0; i < 8; i++)
      x.q[2*i+:2] = !x.m[i] ? 2'h0 : i >= 6 ? (ep >= 4 ? 2'h2 : 2'h1) : ep[2:1];
    x.p = t ? pr : (p >= 6 ? (ep >= 4 ? 3'h4 : 3'h0) : pprio[p]);
    x.v = ev;
    x.l = !(tbl.exists({ev, s}) && tbl[{ev, s}] == 3'(p));
    tbl[{ev, s}] = 3'(p);
    if (x.f) nfld++;
    else nhit++;
    hp = 3'(p); tg = t; hpr = pr; hvid = v; hd = d; hs = s; hv = 1;
    @(negedge clk);
    while (!hr) @(negedge clk);
    eq.push_back(x);
    @(posedge clk) #1;
  endtask
  task automatic cmp_res(input l2pcf_exp_t x);
    logic [15:0] g;
    g = q;
    for (int i = 0; i < 8; i++) if (!x.m[i]) g[2*i+:2] = 2'h0;
    chk(16'(fv), 16'h1);
    chk(16'(msk), 16'(x.m));
    chk(16'(fl), 16'(x.f));
    chk(16'(tmsk), 16'(x.t));
    chk(g, x.q);
    chk(16'(fp), 16'(x.p));
    chk(16'(fvid), 16'(x.v));
    chk(16'(lrn), 16'(x.l));
  endtask
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      error_cnt++;
      test_done();
    end
  end
  always @(negedge clk) begin
    if (tk) cmp_res(eq.pop_front());
    tk = hv && hr && !rst;
  end
  initial begin
    // Pool addresses land in distinct table slots for every VLAN below 16
    pool_hi = 35'({$random(seed), $random(seed)});
    for (int i = 0; i < 6; i++) pool[i] = {pool_hi, 13'(i * 16)};
    repeat (6) @(posedge clk);
    #1 rst = 0;
    chk(16'(fv), 16'h0);
    chk(16'(hr), 16'h1);
    chk(hc, RST_CNT);
    chk(fc, RST_CNT);
    for (int p = 0; p < 8; p++) begin
      @(posedge clk) #1 cp = 3'(p);
      #1 chk(16'(prd), 16'(RST_PORT_PRIO));
      chk(16'(vrd), 16'(RST_PORT_VID));
    end
    for (int r = 0; r < 3; r++) begin
      @(posedge clk) #1;
      for (int p = 0; p < 8; p++) cfg(p);
      we = 0;
      stall = r[0];
      for (int n = 0; n < 150; n++)
        send({$random(seed)} % 8, 1'($random(seed)), 3'($random(seed)),
          $random(seed) & 1 ? 12'h000 : 12'h005, pool[{$random(seed)} % 6],
          pool[{$random(seed)} % 6]);
      hv = 0;
    end
    stall = 0;
    repeat (4) @(posedge clk);
    #1 chk(hc, 16'(nhit));
    chk(fc, 16'(nfld));
    test_done();
  end
endmodule // l2_priority_cam_forwarding_tb
